// file: src/mxe_pkg.sv
package mxe_pkg;

  localparam int          DATA_W     = 8;
  localparam int          MEM_WORDS  = 16;
  localparam int          MEM_AW     = 4;
  localparam int          PROG_AW    = 12;
  localparam int          PROG_W     = 16;
  localparam int          PAGE_AW    = 4;
  localparam int          OP_W       = 5;
  localparam logic [3:0]  LAST_PAGE  = 4'hF;
  localparam logic [7:0]  ALL_ONES   = 8'hFF;
  localparam logic [7:0]  ONE        = 8'h01;

  // apb map, byte addresses
  localparam logic [7:0]  OFS_ACC    = 8'h00;
  localparam logic [7:0]  OFS_STATUS = 8'h04;
  localparam logic [7:0]  OFS_TPLOW  = 8'h08;
  localparam logic [7:0]  OFS_TPHIGH = 8'h0C;
  localparam logic [7:0]  OFS_THBYTE = 8'h10;
  localparam logic [7:0]  OFS_CTRL   = 8'h14;
  localparam logic [7:0]  OFS_MEM    = 8'h40;
  localparam logic [7:0]  MEM_END    = 8'h7C;

  // status and control bit positions
  localparam int          FLG_C      = 0;
  localparam int          FLG_AC     = 1;
  localparam int          FLG_Z      = 2;
  localparam int          FLG_OV     = 3;
  localparam int          CTRL_HPEN  = 0;

  localparam logic [7:0]  RST_ACC    = 8'h00;
  localparam logic [3:0]  RST_FLAGS  = 4'h0;
  localparam logic [7:0]  RST_TP     = 8'h00;
  localparam logic [7:0]  RST_THBYTE = 8'h00;
  localparam logic        RST_HPEN   = 1'b1;

  typedef enum logic [4:0] {
    OP_NOP                    = 5'h00,
    OP_DEC_SKIP_ZERO_TO_ACC   = 5'h01,
    OP_SET_ALL                = 5'h02,
    OP_SET_BIT                = 5'h03,
    OP_INC_SKIP_ZERO          = 5'h04,
    OP_INC_SKIP_ZERO_TO_ACC   = 5'h05,
    OP_SKIP_BIT_SET           = 5'h06,
    OP_MINUS_ACC              = 5'h07,
    OP_MINUS_TO_MEM           = 5'h08,
    OP_MINUS_IMM              = 5'h09,
    OP_NIBBLE_EXCHANGE        = 5'h0A,
    OP_NIBBLE_EXCHANGE_TO_ACC = 5'h0B,
    OP_SKIP_IF_NULL           = 5'h0C,
    OP_COPY_SKIP_NULL         = 5'h0D,
    OP_SKIP_BIT_CLEAR         = 5'h0E,
    OP_TABLE_READ_PAGE        = 5'h0F,
    OP_TABLE_READ_LAST        = 5'h10,
    OP_XOR_ACC                = 5'h11,
    OP_EXCLUSIVE_OR_TO_MEM    = 5'h12,
    OP_XOR_IMM                = 5'h13
  } mxe_op_e;

  typedef enum logic [1:0] {
    PH_EXEC       = 2'b00,
    PH_SKIP_DUMMY = 2'b01,
    PH_TABLE_WAIT = 2'b10
  } mxe_phase_e;

endpackage

// file: src/mxe_exec_tail.sv
`timescale 1ns/1ps
module mxe_exec_tail (
  input  wire logic                            mclk,
  input  wire logic                            sys_rst,
  input  wire logic [7:0]                      paddr,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic                            instValid,
  input  wire logic [mxe_pkg::OP_W-1:0]        instOp,
  input  wire logic [mxe_pkg::MEM_AW-1:0]      instAddr,
  input  wire logic [2:0]                      instBit,
  input  wire logic [mxe_pkg::DATA_W-1:0]      instImm,
  input  wire logic [mxe_pkg::PAGE_AW-1:0]     curPage,
  output logic                                 instReady,
  output logic                                 skipActive,
  output logic      [mxe_pkg::PROG_AW-1:0]     progAddr,
  input  wire logic [mxe_pkg::PROG_W-1:0]      progData,
  output logic      [mxe_pkg::DATA_W-1:0]      accOut,
  output logic      [3:0]                      flagsOut
);
  import mxe_pkg::*;

  typedef struct packed {
    mxe_phase_e                         phase;
    logic [MEM_WORDS-1:0][DATA_W-1:0]   mem;
    logic [DATA_W-1:0]                  acc;
    logic [3:0]                         flags;
    logic [DATA_W-1:0]                  tpLow;
    logic [DATA_W-1:0]                  tpHigh;
    logic [DATA_W-1:0]                  thByte;
    logic                               hpEn;
    logic [PROG_AW-1:0]                 tblAddr;
    logic [MEM_AW-1:0]                  tblDst;
    logic [31:0]                        rdata;
  } mxe_state_s;

  mxe_state_s q;
  mxe_state_s next_q;

  logic [DATA_W-1:0] mByte;
  logic [DATA_W-1:0] subB;
  logic [DATA_W:0]   diff;
  logic [DATA_W-1:0] incV;
  logic [DATA_W-1:0] decV;
  logic [DATA_W-1:0] swapV;
  logic              take;
  logic              apbAcc;
  logic              memHit;
  logic              regHit;
  logic [MEM_AW-1:0] memIdx;

  ////////////////////////////////////////////////////////////////////////////
  // shared datapath

  assign mByte  = q.mem[instAddr];
  assign subB   = (mxe_op_e'(instOp) == OP_MINUS_IMM) ? instImm : mByte;
  assign diff   = {1'b0, q.acc} - {1'b0, subB};
  assign incV   = mByte + ONE;
  assign decV   = mByte - ONE;
  assign swapV  = {mByte[3:0], mByte[7:4]};

  // apb decode
  assign apbAcc = psel && penable;
  assign memHit = (paddr >= OFS_MEM) && (paddr <= MEM_END) && (paddr[1:0] == 2'b00);
  assign memIdx = paddr[MEM_AW+1:2];
  assign regHit = (paddr == OFS_ACC) || (paddr == OFS_STATUS) || (paddr == OFS_TPLOW) ||
                  (paddr == OFS_TPHIGH) || (paddr == OFS_THBYTE) || (paddr == OFS_CTRL);

  // the core takes no instruction during any apb transfer, but a table read finishing in its wait cycle can still write while software writes
  assign instReady  = !psel && (q.phase != PH_TABLE_WAIT);
  assign take       = instValid && instReady;
  assign skipActive = (q.phase == PH_SKIP_DUMMY);
  assign pready     = 1'b1;
  assign pslverr    = apbAcc && !(memHit || regHit);
  assign prdata     = q.rdata;
  assign progAddr   = q.tblAddr;
  assign accOut     = q.acc;
  assign flagsOut   = q.flags;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_q = q;
    if (take && q.phase == PH_SKIP_DUMMY) begin
      next_q.phase = PH_EXEC;
    end else if (take) begin
      unique case (mxe_op_e'(instOp))
        OP_DEC_SKIP_ZERO_TO_ACC: begin
          next_q.acc = decV;
          if (decV == '0) begin
            next_q.phase = PH_SKIP_DUMMY;
          end
        end
        OP_SET_ALL: begin
          next_q.mem[instAddr] = ALL_ONES;
        end
        OP_SET_BIT: begin
          next_q.mem[instAddr][instBit] = 1'b1;
        end
        OP_INC_SKIP_ZERO: begin
          next_q.mem[instAddr] = incV;
          if (incV == '0) begin
            next_q.phase = PH_SKIP_DUMMY;
          end
        end
        OP_INC_SKIP_ZERO_TO_ACC: begin
          next_q.acc = incV;
          if (incV == '0) begin
            next_q.phase = PH_SKIP_DUMMY;
          end
        end
        OP_SKIP_BIT_SET: begin
          if (mByte[instBit]) begin
            next_q.phase = PH_SKIP_DUMMY;
          end
        end
        OP_MINUS_ACC, OP_MINUS_TO_MEM, OP_MINUS_IMM: begin
          // carry is a not-borrow: set when no borrow out of bit 7
          next_q.flags[FLG_C]  = !diff[DATA_W];
          next_q.flags[FLG_AC] = (q.acc[3:0] >= subB[3:0]);
          next_q.flags[FLG_Z]  = (diff[DATA_W-1:0] == '0);
          next_q.flags[FLG_OV] = (q.acc[7] != subB[7]) && (diff[7] != q.acc[7]);
          if (mxe_op_e'(instOp) == OP_MINUS_TO_MEM) begin
            next_q.mem[instAddr] = diff[DATA_W-1:0];
          end else begin
            next_q.acc = diff[DATA_W-1:0];
          end
        end
        OP_NIBBLE_EXCHANGE: begin
          next_q.mem[instAddr] = swapV;
        end
        OP_NIBBLE_EXCHANGE_TO_ACC: begin
          next_q.acc = swapV;
        end
        OP_SKIP_IF_NULL: begin
          next_q.mem[instAddr] = mByte;
          if (mByte == '0) begin
            next_q.phase = PH_SKIP_DUMMY;
          end
        end
        OP_COPY_SKIP_NULL: begin
          next_q.acc = mByte;
          if (mByte == '0) begin
            next_q.phase = PH_SKIP_DUMMY;
          end
        end
        OP_SKIP_BIT_CLEAR: begin
          if (!mByte[instBit]) begin
            next_q.phase = PH_SKIP_DUMMY;
          end
        end
        OP_TABLE_READ_PAGE: begin
          // without a high pointer the word comes from the current page
          next_q.tblAddr = q.hpEn ? {q.tpHigh[PAGE_AW-1:0], q.tpLow}
                                  : {curPage, q.tpLow};
          next_q.tblDst  = instAddr;
          next_q.phase   = PH_TABLE_WAIT;
        end
        OP_TABLE_READ_LAST: begin
          next_q.tblAddr = {LAST_PAGE, q.tpLow};
          next_q.tblDst  = instAddr;
          next_q.phase   = PH_TABLE_WAIT;
        end
        OP_XOR_ACC, OP_XOR_IMM: begin
          next_q.acc          = q.acc ^ subB2(instOp, instImm, mByte);
          next_q.flags[FLG_Z] = ((q.acc ^ subB2(instOp, instImm, mByte)) == '0);
        end
        OP_EXCLUSIVE_OR_TO_MEM: begin
          next_q.mem[instAddr] = q.acc ^ mByte;
          next_q.flags[FLG_Z]  = ((q.acc ^ mByte) == '0);
        end
        default: begin
        end
      endcase
    end

    // program memory answers combinationally on progAddr; one wait cycle covers it
    if (q.phase == PH_TABLE_WAIT) begin
      next_q.mem[q.tblDst] = progData[DATA_W-1:0];
      next_q.thByte        = progData[PROG_W-1:DATA_W];
      next_q.phase         = PH_EXEC;
    end

    // read data is captured in the setup phase, so the access phase needs no wait
    if (psel && !penable) begin
      next_q.rdata = '0;
      if (memHit) begin
        next_q.rdata[DATA_W-1:0] = q.mem[memIdx];
      end else begin
        unique case (paddr)
          OFS_ACC:    next_q.rdata[DATA_W-1:0] = q.acc;
          OFS_STATUS: next_q.rdata[3:0]        = q.flags;
          OFS_TPLOW:  next_q.rdata[DATA_W-1:0] = q.tpLow;
          OFS_TPHIGH: next_q.rdata[DATA_W-1:0] = q.tpHigh;
          OFS_THBYTE: next_q.rdata[DATA_W-1:0] = q.thByte;
          OFS_CTRL:   next_q.rdata[CTRL_HPEN]  = q.hpEn;
          default:    next_q.rdata             = '0;
        endcase
      end
    end

    if (apbAcc && pwrite) begin
      if (memHit) begin
        next_q.mem[memIdx] = pwdata[DATA_W-1:0];
      end else begin
        unique case (paddr)
          OFS_ACC:    next_q.acc    = pwdata[DATA_W-1:0];
          OFS_STATUS: next_q.flags  = pwdata[3:0];
          OFS_TPLOW:  next_q.tpLow  = pwdata[DATA_W-1:0];
          OFS_TPHIGH: next_q.tpHigh = pwdata[DATA_W-1:0];
          OFS_CTRL:   next_q.hpEn   = pwdata[CTRL_HPEN];
          default:    next_q.acc    = q.acc;
        endcase
      end
    end
  end

  // picks the xor operand: immediate constant or memory byte
  function automatic logic [DATA_W-1:0] subB2(input logic [OP_W-1:0] op,
                                              input logic [DATA_W-1:0] imm,
                                              input logic [DATA_W-1:0] mb);
    subB2 = (mxe_op_e'(op) == OP_XOR_IMM) ? imm : mb;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q.phase   <= PH_EXEC;
      q.mem     <= '0;
      q.acc     <= RST_ACC;
      q.flags   <= RST_FLAGS;
      q.tpLow   <= RST_TP;
      q.tpHigh  <= RST_TP;
      q.thByte  <= RST_THBYTE;
      q.hpEn    <= RST_HPEN;
      q.tblAddr <= '0;
      q.tblDst  <= '0;
      q.rdata   <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule

// file: verif/mxe_exec_tail_assertions.sv
`timescale 1ns/1ps
module mxe_exec_tail_assertions
  import mxe_pkg::*;
(
  input wire logic                        mclk,
  input wire logic                        sys_rst,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pslverr,
  input wire logic                        instValid,
  input wire logic [mxe_pkg::OP_W-1:0]    instOp,
  input wire logic [mxe_pkg::DATA_W-1:0]  instImm,
  input wire logic                        instReady,
  input wire logic                        skipActive,
  input wire logic [mxe_pkg::PROG_AW-1:0] progAddr,
  input wire logic [mxe_pkg::DATA_W-1:0]  accOut,
  input wire logic [3:0]                  flagsOut
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // a dummy cycle is not counted as a taken instruction
  logic run;
  assign run = instValid && instReady && !skipActive;
  a_skip_dummy: assert property (skipActive && instValid && instReady |=> !skipActive && $stable(accOut))
    else $error("dummy cycle changed state");
  a_setall_flags: assert property (run && instOp == OP_SET_ALL |=> $stable(flagsOut))
    else $error("set all changed flags");
  a_setbit_flags: assert property (run && instOp == OP_SET_BIT |=> $stable(flagsOut))
    else $error("set bit changed flags");
  a_swap_flags: assert property (run && instOp == OP_NIBBLE_EXCHANGE |=> $stable(flagsOut))
    else $error("swap changed flags");
  a_sub_imm: assert property (run && instOp == OP_MINUS_IMM |=> accOut == $past(accOut) - $past(instImm))
    else $error("subtract immediate result wrong");
  a_sub_carry: assert property (run && instOp == OP_MINUS_IMM |=> flagsOut[0] == ($past(accOut) >= $past(instImm)))
    else $error("subtract carry wrong");
  a_xor_imm: assert property (run && instOp == OP_XOR_IMM |=> accOut == ($past(accOut) ^ $past(instImm))
    && flagsOut[2] == (accOut == 8'h00) && $stable(flagsOut[3]) && $stable(flagsOut[1:0]))
    else $error("xor immediate wrong");
  a_last_page: assert property (run && instOp == OP_TABLE_READ_LAST |=> progAddr[11:8] == LAST_PAGE)
    else $error("last page address wrong");
  a_table_wait: assert property (run && instOp == OP_TABLE_READ_PAGE |=> !instReady ##1 (instReady || psel))
    else $error("table wait cycle wrong");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access");
  a_busy_apb: assert property (psel |-> !instReady)
    else $error("instruction taken during bus cycle");
endmodule
bind mxe_exec_tail mxe_exec_tail_assertions i_chk (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pslverr(pslverr), .instValid(instValid), .instOp(instOp), .instImm(instImm),
  .instReady(instReady), .skipActive(skipActive), .progAddr(progAddr), .accOut(accOut), .flagsOut(flagsOut));

// file: verif/mcu_instruction_execute_tail_tb.sv
`timescale 1ns/1ps
module mcu_instruction_execute_tail_tb;
  import mxe_pkg::*;
  logic        mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, instValid = 1'b0;
  logic [7:0]  paddr = 8'h00, instImm = 8'h00, accOut, acc, tpl, tph, thb;
  logic [31:0] pwdata = 32'h0, prdata, rd, r;
  logic [4:0]  instOp = 5'h00;
  logic [3:0]  instAddr = 4'h0, curPage = 4'h0, flagsOut, fl, a;
  logic [2:0]  instBit = 3'h0;
  logic [11:0] progAddr;
  logic [15:0] progData;
  logic        pready, pslverr, instReady, skipActive, err, hpen, skp;
  logic [7:0]  mem [16];
  int          n_errors = 0, num_checks = 0, cyc = 0, seed;
  ////////////////////////////////////////////////////////////////
  // program memory: the word is a simple function of its address
  assign progData = {progAddr[7:0] ^ 8'h5A, progAddr[11:4]};
  mxe_exec_tail i_dut (.mclk(mclk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instValid(instValid), .instOp(instOp), .instAddr(instAddr), .instBit(instBit), .instImm(instImm),
    .curPage(curPage), .instReady(instReady), .skipActive(skipActive), .progAddr(progAddr),
    .progData(progData), .accOut(accOut), .flagsOut(flagsOut));
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // the read-only latch has no branch here, so a write to it leaves the model alone
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    apb(1'b1, ad, {24'h0, d});
    if (ad >= OFS_MEM) mem[ad[5:2]] = d;
    else if (ad == OFS_ACC) acc = d;
    else if (ad == OFS_TPLOW) tpl = d;
    else if (ad == OFS_TPHIGH) tph = d;
    else if (ad == OFS_CTRL) hpen = d[CTRL_HPEN];
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
    apb(1'b0, ad, 32'h0);
    chk(rd, {24'h0, e});
    chk({31'h0, err}, {31'h0, ad == 8'h20});
  endtask
  task automatic exec(input logic [4:0] op, input logic [3:0] ma, input logic [2:0] b, input logic [7:0] x);
    logic [7:0]  v;
    logic [7:0]  o;
    logic [7:0]  res;
    logic [11:0] pa;
    logic        ns;
    @(posedge mclk);
    instValid <= 1'b1;
    instOp    <= op;
    instAddr  <= ma;
    instBit   <= b;
    instImm   <= x;
    #1;
    while (instReady !== 1'b1) @(posedge mclk) #1;
    @(posedge mclk);
    instValid <= 1'b0;
    v  = mem[ma];
    ns = 1'b0;
    if (!skp) begin
      case (op)
        OP_DEC_SKIP_ZERO_TO_ACC:   acc = v - 8'h01;
        OP_SET_ALL:                mem[ma] = ALL_ONES;
        OP_SET_BIT:                mem[ma][b] = 1'b1;
        OP_INC_SKIP_ZERO:          mem[ma] = v + 8'h01;
        OP_INC_SKIP_ZERO_TO_ACC:   acc = v + 8'h01;
        OP_NIBBLE_EXCHANGE:        mem[ma] = {v[3:0], v[7:4]};
        OP_NIBBLE_EXCHANGE_TO_ACC: acc = {v[3:0], v[7:4]};
        OP_COPY_SKIP_NULL:         acc = v;
        OP_MINUS_ACC, OP_MINUS_TO_MEM, OP_MINUS_IMM: begin
          o   = (op == OP_MINUS_IMM) ? x : v;
          res = acc - o;
          fl  = {(acc[7] != o[7]) && (res[7] != acc[7]), res == 8'h00, acc[3:0] >= o[3:0], acc >= o};
          if (op == OP_MINUS_TO_MEM) mem[ma] = res;
          else acc = res;
        end
        OP_XOR_ACC, OP_EXCLUSIVE_OR_TO_MEM, OP_XOR_IMM: begin
          res = acc ^ ((op == OP_XOR_IMM) ? x : v);
          fl[FLG_Z] = (res == 8'h00);
          if (op == OP_EXCLUSIVE_OR_TO_MEM) mem[ma] = res;
          else acc = res;
        end
        OP_TABLE_READ_PAGE, OP_TABLE_READ_LAST: begin
          pa = (op == OP_TABLE_READ_LAST) ? {LAST_PAGE, tpl} : {(hpen ? tph[3:0] : curPage), tpl};
          // the program word is {addr[7:0] ^ 5A, addr[11:4]}: low byte to memory, high byte to latch
          mem[ma] = pa[11:4];
          thb     = pa[7:0] ^ 8'h5A;
        end
        default: ;
      endcase
      case (op)
        OP_DEC_SKIP_ZERO_TO_ACC, OP_INC_SKIP_ZERO_TO_ACC: ns = (acc == 8'h00);
        OP_INC_SKIP_ZERO:                                 ns = (mem[ma] == 8'h00);
        OP_SKIP_BIT_SET:                                  ns = v[b];
        OP_SKIP_BIT_CLEAR:                                ns = !v[b];
        OP_SKIP_IF_NULL, OP_COPY_SKIP_NULL:               ns = (v == 8'h00);
        default: ;
      endcase
    end
    skp = ns;
    #1;
    chk(32'(accOut), 32'(acc));
    chk(32'(flagsOut), 32'(fl));
    chk(32'(skipActive), 32'(skp));
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    seed = $urandom(11475);
    {acc, tpl, tph, thb, fl, skp, hpen} = {36'h0, 1'b0, 1'b1};
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rdc(OFS_ACC, RST_ACC);
    rdc(OFS_STATUS, 8'h00);
    rdc(OFS_TPLOW, RST_TP);
    rdc(OFS_CTRL, 8'h01);
    rdc(8'h20, 8'h00);
    wr(OFS_THBYTE, 8'hA5);
    rdc(OFS_THBYTE, thb);
    // memory values lean on 00, FF and 01 so that skips are taken often
    for (int i = 0; i < 600; i++) begin
      r = $urandom;
      a = r[31:28];
      if (r[1:0] == 2'b00) wr(OFS_MEM + {2'b00, a, 2'b00}, r[3] ? (r[2] ? 8'h01 : r[15:8]) : {8{r[2]}});
      if (r[5:4] == 2'b00) wr(OFS_TPLOW + {5'h00, r[6], 2'b00}, r[23:16]);
      if (r[9:7] == 3'b000) wr(OFS_CTRL, {7'h00, r[10]});
      if (r[12:11] == 2'b00) wr(OFS_ACC, r[27:20]);
      curPage <= r[19:16];
      exec(5'($urandom_range(19)), a, 3'($urandom_range(7)), 8'($urandom_range(255)));
      if (r[14:13] == 2'b00) rdc(OFS_MEM + {2'b00, a, 2'b00}, mem[a]);
      if (r[14:13] == 2'b01) rdc(OFS_THBYTE, thb);
    end
    for (int i = 0; i < 16; i++) rdc(OFS_MEM + 8'(4 * i), mem[i]);
    final_report();
  end
endmodule
